// >>> design/isp_i2c_slave.sv
/*
  two-wire bus target giving a bus master access to the mode registers.
  assumes clk_link is the device sample clock (8..40 MHz), bus pins are
  open drain and combined outside, clk_sys is unrelated in phase.
*/
// What this block does
// - acts only as a bus target, standard and fast speed.
// - address is 10011 followed by the two device-select pins.
// - answers only when the received address matches its own.
// - never masters; receives on write, transmits on read.
// - first written byte loads the index, later bytes go to indexed register.
// - index increments by one after each accepted byte written after the index byte.
// - index 0x7F increments to 0x0.
// - writes to undefined indexes are not acknowledged.
// - index increments by one after each transmitted byte the master acknowledges.
// - first read after a write returns the index without incrementing.
// - reads at 0x10..0x1F always drive a data byte.
// - bus lines are de-glitched by sampling with the sample clock.
// - filter only guaranteed for sparse spikes and 8..40 MHz clock.
// - slow clock with short high plus hold and spikes reads bit low.
// - slow clock with short start hold and spikes misses start.
// - fast clock with long spikes near falling edge fakes start/stop.
// - mode registers sit at indexes 16..21 with their defaults.
`timescale 1ns/1ps
module isp_i2c_slave (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              clk_link,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  input  wire logic              devSelPinHigh,
  input  wire logic              devSelPinLow,
  output isp_pkg::isp_mode_t     modeRegs
);

  function automatic logic isDefined(input logic [6:0] idx);
    isDefined = (idx >= isp_pkg::IDX_FIRST_DEF) &&
                (idx <= isp_pkg::IDX_LAST_DEF);
  endfunction : isDefined

  function automatic logic [2:0] slotOf(input logic [6:0] idx);
    logic [6:0] off;
    off    = idx - isp_pkg::IDX_FIRST_DEF;
    slotOf = off[2:0];
  endfunction : slotOf

  // reset synchronisers, one per domain
  logic [1:0] rstSys_q;
  logic [1:0] rstLink_q;
  logic       rstSysN;
  logic       rstLinkN;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstSys_q <= 2'h0;
    end else begin
      rstSys_q <= {rstSys_q[0], 1'b1};
    end
  end

  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      rstLink_q <= 2'h0;
    end else begin
      rstLink_q <= {rstLink_q[0], 1'b1};
    end
  end

  assign rstSysN  = rstSys_q[1];
  assign rstLinkN = rstLink_q[1];

  // pin sampling: two flops, then a one-sample agreement filter.
  // a level must hold two samples to pass, so spikes under one period die,
  // at the price of the known misreads at extreme clock rates
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic [1:0] selHiSync_q;
  logic [1:0] selLoSync_q;
  logic       sclLast_q;
  logic       sdaLast_q;
  logic       sclF_q;
  logic       sdaF_q;
  logic       sclP_q;
  logic       sdaP_q;
  logic       sclF_d;
  logic       sdaF_d;

  always_comb begin
    sclF_d = (sclSync_q[1] == sclLast_q) ? sclSync_q[1] : sclF_q;
    sdaF_d = (sdaSync_q[1] == sdaLast_q) ? sdaSync_q[1] : sdaF_q;
  end

  always_ff @(posedge clk_link or negedge rstLinkN) begin
    if (!rstLinkN) begin
      sclSync_q   <= 2'h3;
      sdaSync_q   <= 2'h3;
      selHiSync_q <= 2'h0;
      selLoSync_q <= 2'h0;
      sclLast_q   <= 1'b1;
      sdaLast_q   <= 1'b1;
      sclF_q      <= 1'b1;
      sdaF_q      <= 1'b1;
      sclP_q      <= 1'b1;
      sdaP_q      <= 1'b1;
    end else begin
      sclSync_q   <= {sclSync_q[0], sclIn};
      sdaSync_q   <= {sdaSync_q[0], sdaIn};
      selHiSync_q <= {selHiSync_q[0], devSelPinHigh};
      selLoSync_q <= {selLoSync_q[0], devSelPinLow};
      sclLast_q   <= sclSync_q[1];
      sdaLast_q   <= sdaSync_q[1];
      sclF_q      <= sclF_d;
      sdaF_q      <= sdaF_d;
      sclP_q      <= sclF_q;
      sdaP_q      <= sdaF_q;
    end
  end

  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [6:0] ownAddr;

  assign sclRise   = sclF_q & ~sclP_q;
  assign sclFall   = ~sclF_q & sclP_q;
  assign startSeen = sclF_q & sclP_q & sdaP_q & ~sdaF_q;
  assign stopSeen  = sclF_q & sclP_q & ~sdaP_q & sdaF_q;
  assign ownAddr   = {isp_pkg::ADDR_FIXED, selHiSync_q[1], selLoSync_q[1]};

  // link engine
  isp_pkg::isp_state_t state_q, state_d;
  logic [3:0]          bitCnt_q, bitCnt_d;
  logic [7:0]          shift_q, shift_d;
  logic [6:0]          index_q, index_d;
  logic                readDir_q, readDir_d;
  logic                firstByte_q, firstByte_d;
  logic                oe_q, oe_d;
  logic                wrTgl_q, wrTgl_d;
  logic [7:0]          regs_q [isp_pkg::NUM_REGS];
  logic [7:0]          regs_d [isp_pkg::NUM_REGS];
  logic [7:0]          rdByte;
  isp_pkg::isp_mode_t  linkMode;

  assign linkMode = '{regs_q[0], regs_q[1], regs_q[2],
                      regs_q[3], regs_q[4], regs_q[5]};
  assign rdByte   = isDefined(index_q) ? regs_q[slotOf(index_q)]
                                       : isp_pkg::UNDEF_DATA;

  always_comb begin
    state_d     = state_q;
    bitCnt_d    = bitCnt_q;
    shift_d     = shift_q;
    index_d     = index_q;
    readDir_d   = readDir_q;
    firstByte_d = firstByte_q;
    oe_d        = oe_q;
    wrTgl_d     = wrTgl_q;
    for (int i = 0; i < isp_pkg::NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (startSeen) begin
      // repeated start also lands here; index is kept
      state_d  = isp_pkg::ST_ADDR;
      bitCnt_d = 4'h0;
      oe_d     = 1'b0;
    end else if (stopSeen) begin
      state_d = isp_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        isp_pkg::ST_IDLE: begin
          oe_d = 1'b0;
        end
        isp_pkg::ST_ADDR: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaF_q};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == isp_pkg::BITS_PER_BYTE) begin
            bitCnt_d = 4'h0;
            if (shift_q[7:1] == ownAddr) begin
              readDir_d = shift_q[0];
              oe_d      = 1'b1;
              state_d   = isp_pkg::ST_ADDRACK;
            end else begin
              state_d = isp_pkg::ST_IDLE;
            end
          end
        end
        isp_pkg::ST_ADDRACK: begin
          if (sclFall) begin
            bitCnt_d = 4'h0;
            if (readDir_q) begin
              shift_d = rdByte;
              oe_d    = ~rdByte[7];
              state_d = isp_pkg::ST_RDBYTE;
            end else begin
              oe_d        = 1'b0;
              firstByte_d = 1'b1;
              state_d     = isp_pkg::ST_WRBYTE;
            end
          end
        end
        isp_pkg::ST_WRBYTE: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaF_q};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == isp_pkg::BITS_PER_BYTE) begin
            bitCnt_d = 4'h0;
            if (firstByte_q) begin
              index_d     = shift_q[6:0];
              firstByte_d = 1'b0;
              oe_d        = 1'b1;
              state_d     = isp_pkg::ST_WRACK;
            end else if (isDefined(index_q)) begin
              regs_d[slotOf(index_q)] = shift_q;
              index_d = index_q + 7'h01;
              wrTgl_d = ~wrTgl_q;
              oe_d    = 1'b1;
              state_d = isp_pkg::ST_WRACK;
            end else begin
              state_d = isp_pkg::ST_IDLE;
            end
          end
        end
        isp_pkg::ST_WRACK: begin
          if (sclFall) begin
            oe_d    = 1'b0;
            state_d = isp_pkg::ST_WRBYTE;
          end
        end
        isp_pkg::ST_RDBYTE: begin
          if (sclRise) begin
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_q == isp_pkg::BITS_PER_BYTE) begin
              bitCnt_d = 4'h0;
              oe_d     = 1'b0;
              state_d  = isp_pkg::ST_RDACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d    = ~shift_q[6];
            end
          end
        end
        isp_pkg::ST_RDACK: begin
          if (sclRise) begin
            if (sdaF_q) begin
              state_d = isp_pkg::ST_IDLE;
            end else begin
              index_d = index_q + 7'h01;
            end
          end else if (sclFall) begin
            shift_d = rdByte;
            oe_d    = ~rdByte[7];
            state_d = isp_pkg::ST_RDBYTE;
          end
        end
        default: begin
          state_d = isp_pkg::ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link or negedge rstLinkN) begin
    if (!rstLinkN) begin
      state_q     <= isp_pkg::ST_IDLE;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      index_q     <= 7'h00;
      readDir_q   <= 1'b0;
      firstByte_q <= 1'b0;
      oe_q        <= 1'b0;
      wrTgl_q     <= 1'b0;
      regs_q[0]   <= isp_pkg::RST_ATTN_L;
      regs_q[1]   <= isp_pkg::RST_ATTN_R;
      regs_q[2]   <= isp_pkg::RST_CTRL18;
      regs_q[3]   <= isp_pkg::RST_CTRL19;
      regs_q[4]   <= isp_pkg::RST_CTRL20;
      regs_q[5]   <= isp_pkg::RST_CTRL21;
    end else begin
      state_q     <= state_d;
      bitCnt_q    <= bitCnt_d;
      shift_q     <= shift_d;
      index_q     <= index_d;
      readDir_q   <= readDir_d;
      firstByte_q <= firstByte_d;
      oe_q        <= oe_d;
      wrTgl_q     <= wrTgl_d;
      for (int i = 0; i < isp_pkg::NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // open drain: the only level ever driven is low
  assign sdaOe  = oe_q;
  assign sdaOut = 1'b0;

  // toggle crossing into clk_sys; bytes are many sys cycles apart, so the
  // register image is stable when the toggle edge is seen
  logic [2:0]         tglSync_q, tglSync_d;
  isp_pkg::isp_mode_t mode_q, mode_d;

  always_comb begin
    tglSync_d = {tglSync_q[1:0], wrTgl_q};
    mode_d    = (tglSync_q[2] != tglSync_q[1]) ? linkMode : mode_q;
  end

  always_ff @(posedge clk_sys or negedge rstSysN) begin
    if (!rstSysN) begin
      tglSync_q <= 3'h0;
      mode_q    <= isp_pkg::MODE_RST;
    end else begin
      tglSync_q <= tglSync_d;
      mode_q    <= mode_d;
    end
  end

  assign modeRegs = mode_q;

endmodule : isp_i2c_slave

// >>> dv/isp_i2c_master_model.sv
/* far-side bus master: start, stop and bytes, paced by the link clock.
   assumes the bench resolves the open-drain data wire with a pull-up. */
`timescale 1ns/1ps
module isp_i2c_master_model (
  input  wire logic clkLink,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clkLink);
  endtask : wt

  // data moves 2 cycles after clock low, never beside the clock edge
  task automatic start();
    wt(2);
    sdaDrv <= 1'b1;
    wt(5);
    scl <= 1'b1;
    wt(5);
    sdaDrv <= 1'b0;
    wt(5);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    wt(2);
    sdaDrv <= 1'b0;
    wt(5);
    scl <= 1'b1;
    wt(5);
    sdaDrv <= 1'b1;
    wt(5);
  endtask : stop

  task automatic xfer(input logic [7:0] d, input logic mAck,
                      output logic [7:0] q, output logic sAck);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, mAck};
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      sdaDrv <= tx[i];
      wt(5);
      scl <= 1'b1;
      wt(5);
      rx[i] = sdaWire;
      scl <= 1'b0;
    end
    q = rx[8:1];
    sAck = ~rx[0];
  endtask : xfer
endmodule : isp_i2c_master_model

// >>> dv/isp_i2c_slave_asserts.sv
/* checker for the register port: bus drive and mode image properties.
   assumes it is bound to the top module; the two clocks are unrelated. */
`timescale 1ns/1ps
module isp_i2c_slave_asserts (
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic               clk_link,
  input wire logic               sclIn,
  input wire logic               sdaOut,
  input wire logic               sdaOe,
  input wire isp_pkg::isp_mode_t modeRegs
);
  // bus hold low: a read of zero bytes stays below this
  localparam int RUN_MAX = 110;
  logic [7:0] oeRun_q;
  logic [7:0] oeRun_d;

  always_comb oeRun_d = sdaOe ? oeRun_q + 8'h01 : 8'h00;
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) oeRun_q <= 8'h00;
    else oeRun_q <= oeRun_d;
  end

  function automatic int nDiff(input isp_pkg::isp_mode_t x,
                               input isp_pkg::isp_mode_t y);
    int n;
    n = 0;
    for (int k = 0; k < 6; k++) n += int'(x[8*k +: 8] != y[8*k +: 8]);
    return n;
  endfunction : nDiff

  property p_out_zero;
    @(posedge clk_link) disable iff (!nrst) sdaOut == 1'b0;
  endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("data drive value not zero");
  property p_rst_oe;
    @(posedge clk_link) disable iff (!nrst) $rose(nrst) |-> !sdaOe ##1 !sdaOe;
  endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("data line pulled right after reset");
  property p_rst_regs;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(nrst) |-> modeRegs == isp_pkg::MODE_RST;
  endproperty
  a_rst_regs: assert property (p_rst_regs)
    else $error("mode image not at defaults after reset");
  property p_oe_rise_low;
    @(posedge clk_link) disable iff (!nrst) $rose(sdaOe) |-> !sclIn;
  endproperty
  a_oe_rise_low: assert property (p_oe_rise_low)
    else $error("data pulled while bus clock high");
  property p_oe_high_stable;
    @(posedge clk_link) disable iff (!nrst)
      sclIn && $past(sclIn) |-> $stable(sdaOe);
  endproperty
  a_oe_high_stable: assert property (p_oe_high_stable)
    else $error("data drive changed during clock high");
  property p_idle;
    @(posedge clk_link) disable iff (!nrst) sclIn [*8] |-> !sdaOe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("data pulled on an idle bus");
  property p_oe_run;
    @(posedge clk_link) disable iff (!nrst) oeRun_q < 8'(RUN_MAX);
  endproperty
  a_oe_run: assert property (p_oe_run)
    else $error("data line held low too long");
  property p_one_reg;
    @(posedge clk_sys) disable iff (!nrst)
      $changed(modeRegs) |-> nDiff(modeRegs, $past(modeRegs)) == 1;
  endproperty
  a_one_reg: assert property (p_one_reg)
    else $error("more than one mode register changed at once");
endmodule : isp_i2c_slave_asserts

bind isp_i2c_slave isp_i2c_slave_asserts chk (.clk_sys(clk_sys),
  .nrst(nrst), .clk_link(clk_link), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .modeRegs(modeRegs));

// >>> dv/isp_i2c_slave_bench.sv
/* self-checking bench for the register port, random and corner traffic.
   assumes package, design, checker and master model compile first. */
`timescale 1ns/1ps
module isp_i2c_slave_bench;
  logic               clk_sys;
  logic               clk_link;
  logic               nrst;
  logic               selHi;
  logic               selLo;
  logic               sdaOut;
  logic               sdaOe;
  logic               mScl;
  logic               mSda;
  wire                sdaWire;
  isp_pkg::isp_mode_t modeRegs;
  logic [7:0]         shadow [6];
  logic [7:0]         q;
  logic               a;
  int                 errors;
  int                 checks_done;

  // pull-up: a released line reads high
  assign sdaWire = mSda & ~sdaOe;

  isp_i2c_slave uut (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link),
    .sclIn(mScl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .devSelPinHigh(selHi), .devSelPinLow(selLo), .modeRegs(modeRegs));
  isp_i2c_master_model mst (.clkLink(clk_link), .sdaWire(sdaWire),
    .scl(mScl), .sdaDrv(mSda));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #24 clk_link = ~clk_link;
  end

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [7:0] expRd(input logic [6:0] i);
    if (i >= 7'h10 && i <= 7'h15) return shadow[i - 7'h10];
    return isp_pkg::UNDEF_DATA;
  endfunction : expRd

  task automatic sendAddr(input logic rw);
    mst.start();
    mst.xfer({isp_pkg::ADDR_FIXED, selHi, selLo, rw}, 1'b1, q, a);
    chk(a === 1'b1, "address acknowledge");
  endtask : sendAddr

  task automatic wrByte(input logic [7:0] d, input logic expAck);
    mst.xfer(d, 1'b1, q, a);
    chk(a === expAck, "write acknowledge");
  endtask : wrByte

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial begin
    repeat (10000) @(posedge clk_link);
    errors++;
    complete_run();
  end

  initial begin
    logic [6:0] idx;
    logic [7:0] d;
    void'($urandom(63104));
    errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    {selHi, selLo} = 2'($urandom);
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_link);
    for (int k = 0; k < 6; k++) shadow[k] = isp_pkg::MODE_RST[47-8*k -: 8];
    chk(modeRegs === isp_pkg::MODE_RST && sdaOe === 1'b0, "reset");
    // every select value plus one wrong fixed part
    for (int s = 0; s < 5; s++) begin
      mst.start();
      d = {(s == 4) ? 5'h12 : isp_pkg::ADDR_FIXED, 2'(s), 1'b0};
      mst.xfer(d, 1'b1, q, a);
      chk(a === (s == {selHi, selLo}), "address match");
      mst.stop();
    end
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_sys) {selHi, selLo} <= 2'($urandom);
      repeat (4) @(posedge clk_link);
      idx = 7'h10 + 7'($urandom_range(5));
      sendAddr(1'b0);
      wrByte({1'b0, idx}, 1'b1);
      while (idx <= 7'h15) begin
        d = 8'($urandom);
        wrByte(d, 1'b1);
        shadow[idx - 7'h10] = d;
        idx++;
      end
      wrByte(8'($urandom), 1'b0);
      mst.stop();
      repeat (4) @(posedge clk_link);
      chk(modeRegs === {shadow[0], shadow[1], shadow[2], shadow[3],
                        shadow[4], shadow[5]}, "mode image");
    end
    // start inside the block, in the undefined span, and at the wrap
    for (int j = 0; j < 3; j++) begin
      idx = (j == 0) ? 7'h10 + 7'($urandom_range(3)) :
            (j == 1) ? 7'h1C : 7'h7F;
      sendAddr(1'b0);
      wrByte({1'b0, idx}, 1'b1);
      if (j == 0) begin
        d = 8'($urandom);
        wrByte(d, 1'b1);
        shadow[idx - 7'h10] = d;
        idx++;
      end
      sendAddr(1'b1);
      for (int n = 0; n < 4; n++) begin
        mst.xfer(8'hFF, n == 3, q, a);
        chk(q === expRd(idx), "read data");
        idx++;
      end
      mst.stop();
      chk(sdaOe === 1'b0, "line released after read");
    end
    complete_run();
  end
endmodule : isp_i2c_slave_bench

// >>> include/isp_pkg.sv
/*
  constants, carrier types and reset values for the two-wire register port.
  assumes nothing beyond a sv-2012 compiler.
*/
package isp_pkg;

  localparam logic [4:0] ADDR_FIXED    = 5'h13;
  localparam int         IDX_W         = 7;
  localparam logic [6:0] IDX_FIRST_DEF = 7'h10;
  localparam logic [6:0] IDX_LAST_DEF  = 7'h15;
  localparam int         NUM_REGS      = 6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] RST_ATTN_L    = 8'h00;
  localparam logic [7:0] RST_ATTN_R    = 8'h00;
  localparam logic [7:0] RST_CTRL18    = 8'h00;
  localparam logic [7:0] RST_CTRL19    = 8'h00;
  localparam logic [7:0] RST_CTRL20    = 8'h00;
  localparam logic [7:0] RST_CTRL21    = 8'h00;
  localparam logic [7:0] UNDEF_DATA    = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_ADDRACK = 3'h2,
    ST_WRBYTE  = 3'h3,
    ST_WRACK   = 3'h4,
    ST_RDBYTE  = 3'h5,
    ST_RDACK   = 3'h6
  } isp_state_t;

  typedef struct packed {
    logic [7:0] attnLeft;
    logic [7:0] attnRight;
    logic [7:0] ctrl18;
    logic [7:0] ctrl19;
    logic [7:0] ctrl20;
    logic [7:0] ctrl21;
  } isp_mode_t;

  localparam isp_mode_t MODE_RST = '{RST_ATTN_L, RST_ATTN_R, RST_CTRL18,
                                     RST_CTRL19, RST_CTRL20, RST_CTRL21};

endpackage : isp_pkg
